// *** async_serial_port_with_infrared_tb_top.sv ***
// Testbench: drives the serial port over Wishbone against a far-end peer.
// Assumes package, design, checker and peer are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module async_serial_port_with_infrared_tb_top;
  logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, sin_i, sir_in_i, cts_n_i;
  logic ack_o, sout_o, sir_out_n_o, rts_n_o, baudout_n_o;
  logic [5:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [11:0] f, e;
  logic [7:0] b, fmt;
  int bad_count, num_checks, cycles;
  integer seed;

  serial_port dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .sin_i, .sout_o, .sir_in_i, .sir_out_n_o, .cts_n_i, .rts_n_o,
    .baudout_n_o);
  serial_peer peer (.clk_i, .sout_i(sout_o), .sir_out_n_i(sir_out_n_o), .sin_o(sin_i),
    .sir_in_o(sir_in_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  // ----------------------------------------
  // Bus, model and closing tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wb(input bit w, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 64);
    if (t >= 64) bad_count++;
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic poll(input int k, output logic [31:0] r);
    int t;
    t = 0;
    do begin
      wb(1'b0, serial_port_pkg::line_status_addr, 32'h0, r);
      t++;
    end while (r[k] !== 1'b1 && t < 300);
    `CHK(r[k], 1'b1)
  endtask
  function automatic logic [11:0] frame(input logic [7:0] d, input int len, input bit pe,
                                        input bit ev);
    logic [11:0] x;
    logic p;
    x = '1;
    p = 1'b0;
    x[0] = 1'b0;
    for (int i = 0; i < len; i++) begin
      x[i + 1] = d[i];
      p = p ^ d[i];
    end
    if (pe) x[len + 1] = ev ? p : ~p;
    return x;
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'ha57a;
    {rst_i, ce_i, cts_n_i, cyc_i, stb_i, we_i} = 6'h30;
    adr_i = 6'h00;
    sel_i = 4'h1;
    dat_i = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(sout_o, 1'b1)
    `CHK(sir_out_n_o, 1'b1)
    wb(1'b0, serial_port_pkg::char_format_register_addr, 32'h0, q);
    `CHK(q[7:0], serial_port_pkg::fmt_reset)
    wb(1'b0, 6'h3c, 32'h0, q);
    `CHK(q, 32'h0)
    for (int i = 0; i < 5; i++) begin
      fmt = (8'($random(seed)) & 8'h1c) | 8'(i % 4);
      if (i == 4) begin
        wb(1'b1, serial_port_pkg::divisor_low_addr, 32'h2, q);
        wb(1'b1, serial_port_pkg::divisor_fraction_addr, 32'h8, q);
        fmt = 8'h00;
      end
      wb(1'b1, serial_port_pkg::char_format_register_addr, {24'h0, fmt}, q);
      repeat (8) @(posedge clk_i);
      b = 8'($random(seed));
      e = frame(b, 5 + i % 4, fmt[3], fmt[4]);
      fork
        wb(1'b1, serial_port_pkg::data_addr, {24'h0, b}, q);
        peer.grab(1'b0, 7 + i % 4 + fmt[3], (i == 4) ? 40 : 16, f);
      join
      `CHK(f, e)
      repeat (100) @(posedge clk_i);
    end
    wb(1'b1, serial_port_pkg::divisor_low_addr, 32'h1, q);
    wb(1'b1, serial_port_pkg::divisor_fraction_addr, 32'h0, q);
    wb(1'b1, serial_port_pkg::char_format_register_addr, 32'h1b, q);
    repeat (8) @(posedge clk_i);
    for (int k = 0; k < 2; k++) begin
      b = 8'($random(seed));
      e = frame(b, 8, 1'b1, 1'b1);
      e[9] = e[9] ^ k[0];
      peer.send(e, 11, 1'b0, 16);
      poll(0, q);
      `CHK(q[2], k[0])
      wb(1'b0, serial_port_pkg::data_addr, 32'h0, q);
      `CHK(q[7:0], b)
    end
    peer.send(12'h000, 12, 1'b0, 16);
    poll(4, q);
    wb(1'b0, serial_port_pkg::data_addr, 32'h0, q);
    wb(1'b1, serial_port_pkg::char_format_register_addr, 32'h5b, q);
    repeat (40) @(posedge clk_i);
    `CHK(sout_o, 1'b0)
    wb(1'b1, serial_port_pkg::char_format_register_addr, 32'h00, q);
    repeat (40) @(posedge clk_i);
    `CHK(sout_o, 1'b1)
    wb(1'b1, serial_port_pkg::modem_ctrl_register_addr, 32'h40, q);
    repeat (8) @(posedge clk_i);
    b = 8'($random(seed));
    e = frame(b, 8, 1'b0, 1'b0);
    fork
      wb(1'b1, serial_port_pkg::data_addr, {24'h0, b}, q);
      peer.grab(1'b1, 10, 16, f);
    join
    `CHK(f, e)
    `CHK(sout_o, 1'b1)
    repeat (60) @(posedge clk_i);
    b = 8'($random(seed));
    peer.send(frame(b, 8, 1'b0, 1'b0), 10, 1'b1, 16);
    poll(0, q);
    wb(1'b0, serial_port_pkg::data_addr, 32'h0, q);
    `CHK(q[7:0], b)
    conclude();
  end
endmodule

// *** serial_peer.sv ***
// Partner: far-end device on the plain and infrared serial lines.
// Assumes one frame at a time; bit period given in clocks.
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input wire logic clk_i,
  // Lines from the port
  input wire logic sout_i,
  input wire logic sir_out_n_i,
  // Lines to the port
  output logic sin_o,
  output logic sir_in_o
);
  initial begin
    sin_o = 1'b1;
    sir_in_o = 1'b1;
  end
  // Send frame f, bit 0 first
  task automatic send(input logic [11:0] f, input int n, input bit ir, input int bp);
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < bp; k++) begin
        @(posedge clk_i);
        sin_o <= ir ? 1'b1 : f[i];
        sir_in_o <= (ir && !f[i] && k < 3 * bp / 16) ? 1'b0 : 1'b1;
      end
    end
    @(posedge clk_i);
    sin_o <= 1'b1;
    sir_in_o <= 1'b1;
  endtask
  // Capture n bits at mid-bit, or by pulse presence in infrared
  task automatic grab(input bit ir, input int n, input int bp, output logic [11:0] f);
    int w;
    f = '1;
    w = 0;
    while ((ir ? sir_out_n_i : sout_i) !== 1'b0 && w < 4000) begin
      @(posedge clk_i);
      w++;
    end
    if (!ir) repeat (bp / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      f[i] = ir ? 1'b1 : sout_i;
      for (int k = 0; k < bp; k++) begin
        @(posedge clk_i);
        if (ir && k < bp / 2 && sir_out_n_i === 1'b0) f[i] = 1'b0;
      end
    end
  endtask
endmodule

// *** serial_port.sv ***
// Serial port with programmable framing, fractional divisor and IR encoding.
// Assumes classic Wishbone master; pins synchronous to clk_i.
`timescale 1ns/1ps

module serial_port #(
  parameter int fifo_depth = 16,
  parameter bit has_fifo = 1'b1,
  parameter bit has_infrared = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial pins
  input wire logic sin_i,
  output logic sout_o,
  input wire logic sir_in_i,
  output logic sir_out_n_o,
  input wire logic cts_n_i,
  output logic rts_n_o,
  output logic baudout_n_o
);

  initial begin
    if (fifo_depth < 2 || fifo_depth > 256 || (fifo_depth & (fifo_depth - 1)) != 0) begin
      $error("fifo_depth must be a power of two from 2 to 256");
    end
  end

  localparam int aw = $clog2(fifo_depth);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] char_format_register;
  logic [7:0] modem_ctrl_register;
  logic [15:0] divisor;
  logic [3:0] divisor_fraction;
  logic [15:0] lowpower_divisor;
  logic tx_full;
  logic [7:0] tx_hold;
  serial_port_pkg::rx_char_t rx_mem [fifo_depth];
  logic [aw:0] rx_wp;
  logic [aw:0] rx_rp;
  logic line_event;
  logic timeout_flag;
  logic tx_empty_irq;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire bus_req = cyc_i && stb_i && !ack_o;
  wire wr = bus_req && we_i && sel_i[0];
  wire rd = bus_req && !we_i;
  wire infrared = has_infrared && modem_ctrl_register[serial_port_pkg::modem_infrared_bit];
  wire [aw:0] rx_count = rx_wp - rx_rp;
  wire rx_empty = rx_count == '0;
  wire rx_full = has_fifo ? rx_count[aw] : !rx_empty;
  wire serial_port_pkg::rx_char_t rx_head = rx_mem[rx_rp[aw-1:0]];
  wire rd_data = rd && adr_i == serial_port_pkg::data_addr;
  wire rd_lsr = rd && adr_i == serial_port_pkg::line_status_addr;
  wire rd_iir = rd && adr_i == serial_port_pkg::irq_ident_reg_addr;
  wire wr_data = wr && adr_i == serial_port_pkg::data_addr && !tx_full;
  wire soft_rst = wr && adr_i == serial_port_pkg::soft_reset_addr && dat_i[0];
  wire srst = rst_i || soft_rst;
  wire [7:0] lsr = {1'b0, !tx_full, !tx_full, rx_head.brk && !rx_empty,
                    rx_head.frame_err && !rx_empty, rx_head.parity_err && !rx_empty,
                    1'b0, !rx_empty};
  wire [3:0] iid = line_event ? serial_port_pkg::iid_line :
                   !rx_empty ? serial_port_pkg::iid_rx_data :
                   timeout_flag ? serial_port_pkg::iid_timeout :
                   tx_empty_irq ? serial_port_pkg::iid_tx_empty :
                   serial_port_pkg::iid_none;
  logic [31:0] rd_mux;
  always_comb begin
    unique case (adr_i)
      serial_port_pkg::data_addr: rd_mux = {24'h0, rx_head.data};
      serial_port_pkg::divisor_low_addr: rd_mux = {24'h0, divisor[7:0]};
      serial_port_pkg::divisor_high_byte_addr: rd_mux = {24'h0, divisor[15:8]};
      serial_port_pkg::divisor_fraction_addr: rd_mux = {28'h0, divisor_fraction};
      serial_port_pkg::char_format_register_addr: rd_mux = {24'h0, char_format_register};
      serial_port_pkg::modem_ctrl_register_addr: rd_mux = {24'h0, modem_ctrl_register};
      serial_port_pkg::line_status_addr: rd_mux = {24'h0, lsr};
      serial_port_pkg::irq_ident_reg_addr: rd_mux = {28'h0, iid};
      serial_port_pkg::lowpower_divisor_low_addr: rd_mux = {24'h0, lowpower_divisor[7:0]};
      serial_port_pkg::lowpower_divisor_high_addr: rd_mux = {24'h0, lowpower_divisor[15:8]};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else if (ce_i) begin
      ack_o <= bus_req;
      dat_o <= rd ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst) begin
      char_format_register <= serial_port_pkg::fmt_reset;
      modem_ctrl_register <= 8'h00;
      divisor <= serial_port_pkg::divisor_reset;
      divisor_fraction <= 4'h0;
      lowpower_divisor <= serial_port_pkg::divisor_reset;
    end else if (ce_i && wr) begin
      unique case (adr_i)
        serial_port_pkg::divisor_low_addr: divisor[7:0] <= dat_i[7:0];
        serial_port_pkg::divisor_high_byte_addr: divisor[15:8] <= dat_i[7:0];
        serial_port_pkg::divisor_fraction_addr: divisor_fraction <= dat_i[3:0];
        serial_port_pkg::char_format_register_addr: char_format_register <= dat_i[7:0];
        serial_port_pkg::modem_ctrl_register_addr: modem_ctrl_register <= dat_i[7:0];
        serial_port_pkg::lowpower_divisor_low_addr: lowpower_divisor[7:0] <= dat_i[7:0];
        serial_port_pkg::lowpower_divisor_high_addr: lowpower_divisor[15:8] <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Fractional baud tick generator
  // ----------------------------------------
  logic [15:0] baud_cnt;
  logic [3:0] frac_acc;
  logic tick;
  wire [4:0] frac_sum = {1'b0, frac_acc} + {1'b0, divisor_fraction};
  wire [15:0] reload = frac_sum[4] ? divisor : divisor - 16'h0001;
  always_ff @(posedge clk_i) begin
    if (srst) begin
      baud_cnt <= 16'h0;
      frac_acc <= 4'h0;
      tick <= 1'b0;
      baudout_n_o <= 1'b1;
    end else if (ce_i) begin
      tick <= baud_cnt == 16'h0;
      baudout_n_o <= !(baud_cnt == 16'h0);
      if (baud_cnt == 16'h0) begin
        baud_cnt <= reload;
        frac_acc <= frac_sum[3:0];
      end else begin
        baud_cnt <= baud_cnt - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Frame format
  // ----------------------------------------
  wire [3:0] nbits = infrared ? 4'h8 : 4'h5 + {2'b00, char_format_register[1:0]};
  wire par_en = !infrared && char_format_register[serial_port_pkg::fmt_parity_en_bit];
  wire par_even = char_format_register[serial_port_pkg::fmt_even_bit];
  wire two_stop = !infrared && char_format_register[serial_port_pkg::fmt_stop_bit];
  wire half_stop = two_stop && char_format_register[1:0] == 2'b00;

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  serial_port_pkg::phase_t tx_ph;
  logic [3:0] tx_tick;
  logic [3:0] tx_idx;
  logic [8:0] tx_sh;
  logic tx_line;
  logic tx_busy_stop2;
  wire tx_allowed = !has_fifo || !cts_n_i;
  wire [3:0] tx_last = tx_busy_stop2 && half_stop ? serial_port_pkg::half_last :
                       serial_port_pkg::ticks_last;
  always_ff @(posedge clk_i) begin
    if (srst) begin
      tx_ph <= serial_port_pkg::idle_s;
      tx_tick <= 4'h0;
      tx_idx <= 4'h0;
      tx_sh <= 9'h1ff;
      tx_line <= 1'b1;
      tx_full <= 1'b0;
      tx_hold <= 8'h0;
      tx_busy_stop2 <= 1'b0;
      tx_empty_irq <= 1'b0;
    end else if (ce_i) begin
      if (wr_data) begin
        tx_hold <= dat_i[7:0];
        tx_full <= 1'b1;
        tx_empty_irq <= 1'b0;
      end else if (rd_iir && iid == serial_port_pkg::iid_tx_empty) begin
        tx_empty_irq <= 1'b0;
      end
      if (tick) begin
        unique case (tx_ph)
          serial_port_pkg::idle_s: begin
            if (tx_full && tx_allowed) begin
              tx_sh <= {^tx_hold[7:0] ^ !par_even, tx_hold};
              tx_full <= 1'b0;
              tx_empty_irq <= 1'b1;
              tx_line <= 1'b0;
              tx_tick <= 4'h0;
              tx_ph <= serial_port_pkg::start_s;
            end
          end
          serial_port_pkg::start_s: begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == serial_port_pkg::ticks_last) begin
              tx_line <= tx_sh[0];
              tx_idx <= 4'h1;
              tx_ph <= serial_port_pkg::data_s;
            end
          end
          serial_port_pkg::data_s: begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == serial_port_pkg::ticks_last) begin
              tx_idx <= tx_idx + 4'h1;
              if (tx_idx < nbits) begin
                tx_line <= tx_sh[tx_idx];
              end else if (tx_idx == nbits && par_en) begin
                tx_line <= ^(tx_sh[7:0] & (8'hff >> (4'h8 - nbits))) ^ !par_even;
              end else begin
                tx_line <= 1'b1;
                tx_busy_stop2 <= 1'b0;
                tx_ph <= serial_port_pkg::stop_s;
              end
            end
          end
          serial_port_pkg::stop_s: begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == tx_last) begin
              tx_tick <= 4'h0;
              if (two_stop && !tx_busy_stop2) begin
                tx_busy_stop2 <= 1'b1;
              end else begin
                tx_ph <= serial_port_pkg::idle_s;
              end
            end
          end
        endcase
      end
    end
  end

  wire brk = char_format_register[serial_port_pkg::fmt_break_bit];
  wire ir_pulse = !tx_line && tx_tick < serial_port_pkg::pulse_ticks;
  always_ff @(posedge clk_i) begin
    if (srst) begin
      sout_o <= 1'b1;
      sir_out_n_o <= 1'b1;
      rts_n_o <= 1'b1;
    end else if (ce_i) begin
      sout_o <= infrared ? 1'b1 : tx_line && !brk;
      sir_out_n_o <= !(infrared && (ir_pulse || brk));
      rts_n_o <= has_fifo ? rx_full : 1'b1;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // Infrared pulse is stretched to a full bit so the normal sampler sees it
  logic [3:0] ir_hold;
  logic rx_prev;
  wire ir_low = !sir_in_i;
  // Own transmission masks the infrared receiver
  wire rx_line = infrared ? (ir_hold == 4'h0 || tx_ph != serial_port_pkg::idle_s) : sin_i;
  always_ff @(posedge clk_i) begin
    if (srst) begin
      ir_hold <= 4'h0;
    end else if (ce_i) begin
      if (ir_low) begin
        ir_hold <= serial_port_pkg::ticks_last;
      end else if (tick && ir_hold != 4'h0) begin
        ir_hold <= ir_hold - 4'h1;
      end
    end
  end

  serial_port_pkg::phase_t rx_ph;
  logic [3:0] rx_tick;
  logic [3:0] rx_idx;
  logic [7:0] rx_sh;
  logic rx_par;
  logic [9:0] idle_chars;
  wire rx_push = tick && rx_ph == serial_port_pkg::stop_s && rx_tick == serial_port_pkg::ticks_last;
  wire [7:0] rx_data = rx_sh >> (4'h8 - nbits);
  wire par_bad = par_en && (^rx_data ^ rx_par ^ !par_even);
  wire is_break = !rx_line && rx_sh == 8'h00 && !rx_par;
  always_ff @(posedge clk_i) begin
    if (srst) begin
      rx_ph <= serial_port_pkg::idle_s;
      rx_tick <= 4'h0;
      rx_idx <= 4'h0;
      rx_sh <= 8'h0;
      rx_par <= 1'b0;
      rx_prev <= 1'b1;
    end else if (ce_i && tick) begin
      rx_prev <= rx_line;
      rx_tick <= rx_tick + 4'h1;
      unique case (rx_ph)
        serial_port_pkg::idle_s: begin
          rx_tick <= 4'h0;
          if (rx_prev && !rx_line) begin
            rx_ph <= serial_port_pkg::start_s;
          end
        end
        serial_port_pkg::start_s: begin
          if (rx_tick == serial_port_pkg::ticks_mid) begin
            rx_tick <= 4'h0;
            rx_idx <= 4'h0;
            rx_ph <= rx_line ? serial_port_pkg::idle_s : serial_port_pkg::data_s;
          end
        end
        serial_port_pkg::data_s: begin
          if (rx_tick == serial_port_pkg::ticks_last) begin
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx < nbits) begin
              rx_sh <= {rx_line, rx_sh[7:1]};
            end else begin
              rx_par <= rx_line;
            end
            if (rx_idx + 4'h1 == nbits + {3'b000, par_en}) begin
              rx_ph <= serial_port_pkg::stop_s;
            end
          end
        end
        serial_port_pkg::stop_s: begin
          if (rx_tick == serial_port_pkg::ticks_last) begin
            rx_ph <= serial_port_pkg::idle_s;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rx_push && ce_i && !rx_full) begin
      rx_mem[rx_wp[aw-1:0]] <= '{data: rx_data, parity_err: par_bad,
                                 frame_err: !rx_line, brk: is_break};
    end
  end

  wire rx_pop = rd_data && !rx_empty;
  always_ff @(posedge clk_i) begin
    if (srst) begin
      rx_wp <= '0;
      rx_rp <= '0;
      line_event <= 1'b0;
      timeout_flag <= 1'b0;
      idle_chars <= 10'h0;
    end else if (ce_i) begin
      if (rx_push && !rx_full) begin
        rx_wp <= rx_wp + 1'b1;
      end
      if (rx_pop) begin
        rx_rp <= rx_rp + 1'b1;
      end
      if (rx_push && (par_bad || !rx_line || is_break || rx_full)) begin
        line_event <= 1'b1;
      end else if (rd_lsr) begin
        line_event <= 1'b0;
      end
      if (rx_push || rx_pop || rx_empty) begin
        idle_chars <= 10'h0;
        timeout_flag <= 1'b0;
      end else if (tick && rx_ph == serial_port_pkg::idle_s) begin
        idle_chars <= idle_chars + 10'h1;
        if (idle_chars == 10'(serial_port_pkg::timeout_chars * 10 * 16)) begin
          timeout_flag <= has_fifo;
        end
      end
    end
  end

endmodule

// *** serial_port_pkg.sv ***
// Package: constants and carriers for the infrared-capable serial port.
// Assumes a single clock domain and a classic Wishbone slave bus.
package serial_port_pkg;

  // ----------------------------------------
  // Register word offsets (byte addresses)
  // ----------------------------------------
  localparam logic [5:0] data_addr = 6'h00;
  localparam logic [5:0] divisor_low_addr = 6'h04;
  localparam logic [5:0] divisor_high_byte_addr = 6'h08;
  localparam logic [5:0] divisor_fraction_addr = 6'h0c;
  localparam logic [5:0] char_format_register_addr = 6'h10;
  localparam logic [5:0] modem_ctrl_register_addr = 6'h14;
  localparam logic [5:0] line_status_addr = 6'h18;
  localparam logic [5:0] irq_ident_reg_addr = 6'h1c;
  localparam logic [5:0] lowpower_divisor_low_addr = 6'h20;
  localparam logic [5:0] lowpower_divisor_high_addr = 6'h24;
  localparam logic [5:0] soft_reset_addr = 6'h28;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int fmt_parity_en_bit = 3;
  localparam int fmt_even_bit = 4;
  localparam int fmt_stop_bit = 2;
  localparam int fmt_break_bit = 6;
  localparam int modem_infrared_bit = 6;
  localparam int modem_lowpower_bit = 5;

  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [7:0] fmt_reset = 8'h03;
  localparam logic [15:0] divisor_reset = 16'h0001;
  localparam logic [3:0] iid_line = 4'h6;
  localparam logic [3:0] iid_rx_data = 4'h4;
  localparam logic [3:0] iid_timeout = 4'hc;
  localparam logic [3:0] iid_tx_empty = 4'h2;
  localparam logic [3:0] iid_none = 4'h1;

  // ----------------------------------------
  // Timing constants
  // ----------------------------------------
  localparam logic [3:0] ticks_last = 4'hf;
  localparam logic [3:0] ticks_mid = 4'h7;
  localparam logic [3:0] half_last = 4'h7;
  localparam logic [3:0] pulse_ticks = 4'h3;
  localparam int timeout_chars = 4;
  localparam int fraction_bits = 4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {idle_s, start_s, data_s, stop_s} phase_t;

  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
    logic brk;
  } rx_char_t;

endpackage

// *** serial_port_props.sv ***
// Checker: bus handshake and serial pin timing of serial_port.
// Assumes bound to serial_port; ce_i low pauses every check.
`timescale 1ns/1ps
module serial_port_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pins
  input wire logic sout_o,
  input wire logic sir_out_n_o,
  input wire logic rts_n_o,
  input wire logic baudout_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  // ----------------------------------------
  // Run lengths of low levels
  // ----------------------------------------
  int low_run;
  int ir_ticks;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_run <= 0;
      ir_ticks <= 0;
    end else if (ce_i) begin
      low_run <= sout_o ? 0 : low_run + 1;
      ir_ticks <= sir_out_n_o ? 0 : ir_ticks + int'(!baudout_n_o);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence
  property p_ack_seq;
    s_req |=> s_ans;
  endproperty
  a_ack_seq: assert property (p_ack_seq) else $error("ack late or too long");
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_no_req;
    !(cyc_i && stb_i) |=> !ack_o;
  endproperty
  a_no_req: assert property (p_no_req) else $error("ack while idle");
  property p_unmapped;
    (cyc_i && stb_i && !ack_o && !we_i && adr_i == 6'h3c) |=> dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_idle;
    $fell(rst_i) |-> sout_o && sir_out_n_o && rts_n_o && baudout_n_o && !ack_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
  property p_sout_min;
    $rose(sout_o) |-> low_run >= 16;
  endproperty
  a_sout_min: assert property (p_sout_min) else $error("low bit shorter than period");
  property p_ir_pulse;
    $rose(sir_out_n_o) |-> ir_ticks == 3;
  endproperty
  a_ir_pulse: assert property (p_ir_pulse) else $error("infrared pulse width wrong");
  property p_ir_max;
    !sir_out_n_o |-> ir_ticks <= 2;
  endproperty
  a_ir_max: assert property (p_ir_max) else $error("infrared pulse too long");
endmodule

bind serial_port serial_port_props chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .dat_o, .ack_o, .sout_o, .sir_out_n_o, .rts_n_o, .baudout_n_o);
